// *** ssc_host_model.sv ***
/* behavioural host driving the three-wire serial port.
   assumes a 40 ns aclk; serial clock half period is four aclk. */
`timescale 1ns/10ps
`default_nettype none
module ssc_host_model (
    // system
    input  wire logic aclk,
    // serial pins
    output var logic  serial_clock,
    output var logic  serial_data,
    output var logic  latch_enable
);
    initial begin
        serial_clock = 1'b0;
        serial_data  = 1'b0;
        latch_enable = 1'b1;
    end
    task automatic half;
        repeat (4) @(posedge aclk);
    endtask
    task automatic send_word(input logic [23:0] w);
        latch_enable <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            serial_clock <= 1'b0;
            serial_data  <= w[i];
            half();
            serial_clock <= 1'b1;
            half();
        end
        // clock idles low, released data shows no stale bit
        serial_clock <= 1'b0;
        serial_data  <= ~w[0];
        half();
        latch_enable <= 1'b1;
    endtask
    task automatic idle_clocks(input int n);
        repeat (n) begin
            serial_data  <= ~serial_data;
            serial_clock <= 1'b1;
            half();
            serial_clock <= 1'b0;
            half();
        end
    endtask
endmodule // ssc_host_model
`default_nettype wire

// *** ssc_pkg.sv ***
/*
 * constants and modes of the serial config port.
 * assumes one 25 MHz system clock; all pins are asynchronous to it.
 */
// Notes on behaviour
// (RULE_01) data shifts in on each serial clock rising edge.
// (RULE_02) 24th edge loads the addressed register.
// (RULE_03) latch high: serial clocks ignored, registers unchanged.
// (RULE_04) host holds latch low for all 24 clocks of a word.
// (RULE_05) above 1.4 GHz external oscillator, host writes 0x046110 into the tuning register; the bench sends word 0x466110 (address 0x46).
// (RULE_06) pin FSK: two, four or eight levels.
// (RULE_07) arbitrary FSK levels come via the fast serial path.
// (RULE_08) FSK changes the N-divider, from serial words or pins.
// (RULE_09) pump current sum of the active mode's up and down fields.
// (RULE_10) two modes: synthesizer with internal oscillator, or PLL with external one.
// (RULE_11) modulator order one to four; fractional denominator up to 24 bits.
// (RULE_12) output routes to transmit, receive, or both (1:2 fanout).
// (RULE_13) port switch also switches between the two frequency settings.
// (RULE_14) power-down follows the register bit or an inactive chip enable pin.
// (RULE_15) host supplies reference clock when writing main control.
package ssc_pkg;
    // serial word layout
    localparam int          WORD_BITS   = 24;
    localparam int          ADDR_BITS   = 7;
    localparam int          DATA_BITS   = 16;
    localparam int          ADDR_LSB    = 16;
    localparam int          CNT_BITS    = 5;
    localparam logic [4:0]  WORD_LAST   = 5'h17;
    // bank addresses
    localparam logic [6:0]  BA_MAIN     = 7'h00;
    localparam logic [6:0]  BA_N_ONE    = 7'h01;
    localparam logic [6:0]  BA_N_TWO    = 7'h02;
    localparam logic [6:0]  BA_DEN_LO   = 7'h03;
    localparam logic [6:0]  BA_DEN_HI   = 7'h04;
    localparam logic [6:0]  BA_PUMP_INT = 7'h05;
    localparam logic [6:0]  BA_PUMP_EXT = 7'h06;
    localparam logic [6:0]  BA_FSK_FAST = 7'h07;
    localparam logic [6:0]  BA_FSK_STEP = 7'h08;
    localparam logic [6:0]  BA_HF_TUNE  = 7'h46;
    // main control and pump fields
    localparam int          MC_PD       = 0;
    localparam int          MC_PLL      = 1;
    localparam int          MC_ROUTE    = 2;
    localparam int          MC_FSK      = 4;
    localparam int          MC_LEVELS   = 6;
    localparam int          MC_ORDER    = 8;
    localparam int          MC_MUXSEL   = 10;
    localparam int          PUMP_DN     = 5;
    localparam int          PUMP_W      = 5;
    // modes
    typedef enum logic [1:0] {SSC_ROUTE_TX = 2'b00, SSC_ROUTE_RX = 2'b01,
                              SSC_ROUTE_BOTH = 2'b10, SSC_ROUTE_OFF = 2'b11} ssc_route_t;
    typedef enum logic [1:0] {SSC_FSK_OFF = 2'b00, SSC_FSK_PIN = 2'b01,
                              SSC_FSK_FAST = 2'b10, SSC_FSK_RSV = 2'b11} ssc_fsk_t;
    // axi register byte offsets
    localparam logic [7:0]  AX_CONTROL  = 8'h00;
    localparam logic [7:0]  AX_STATUS   = 8'h04;
    localparam logic [7:0]  AX_BANK_SEL = 8'h08;
    localparam logic [7:0]  AX_BANK_DAT = 8'h0C;
    localparam logic [7:0]  AX_N_ACTIVE = 8'h10;
    localparam logic [7:0]  AX_DEN      = 8'h14;
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;
    localparam logic [1:0]  CTRL_RESET  = 2'b00;
endpackage

// *** ssc_port.sv ***
/*
 * three-wire serial configuration port with register bank, mode decode,
 * FSK N-divider selection and an AXI4-Lite window for software.
 * assumes the serial pins are slow next to aclk (320 ns serial clock period).
 */
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module ssc_port #(
    parameter int BANK_DEPTH = 128
) (
    // system
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // serial pins
    input  wire logic        serial_clock,
    input  wire logic        serial_data,
    input  wire logic        latch_enable,
    input  wire logic        chip_enable,
    output logic             multiplexed_status_out,
    // fsk pins
    input  wire logic [2:0]  fsk_symbol_pins,
    input  wire logic        fsk_symbol_valid,
    // decoded configuration
    output logic             powered_down,
    output logic             pll_mode,
    output logic             tx_enable,
    output logic             rx_enable,
    output logic             freq_sel_two,
    output logic [1:0]       dsm_order,
    output logic [23:0]      fraction_denominator,
    output logic [15:0]      n_divider,
    output logic [5:0]       pump_current_sum,
    output logic             cal_start,
    // axi4-lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    import ssc_pkg::*;

    logic [2:0]           sck_s_q;
    logic [1:0]           sdi_s_q;
    logic [1:0]           le_s_q;
    logic [1:0]           ce_s_q;
    logic [1:0]           fv_s_q;
    logic [2:0]           fsym_s1_q;
    logic [2:0]           fsym_s2_q;
    logic                 sck_rise;
    logic [WORD_BITS-1:0] shift_q;
    logic [WORD_BITS-1:0] shift_d;
    logic [CNT_BITS-1:0]  bit_cnt_q;
    logic                 word_done;
    logic [ADDR_BITS-1:0] wr_addr;
    logic [DATA_BITS-1:0] wr_data;
    logic [DATA_BITS-1:0] bank_q [BANK_DEPTH];
    logic [DATA_BITS-1:0] main_q;
    logic [DATA_BITS-1:0] fast_step_q;
    logic [2:0]           sym_q;
    logic [15:0]          words_q;
    logic                 word_tog_q;
    logic [1:0]           ctrl_q;
    logic [ADDR_BITS-1:0] bank_sel_q;
    logic                 port_lock;
    logic                 soft_pd;
    logic [DATA_BITS-1:0] fsk_step;
    logic [2:0]           sym_mask;
    ssc_route_t           route;
    ssc_fsk_t             fsk_mode;
    logic                 aw_held_q;
    logic                 w_held_q;
    logic [7:0]           aw_addr_q;
    logic [31:0]          w_data_q;
    logic [3:0]           w_strb_q;
    logic                 wr_go;
    logic [31:0]          rd_val;
    logic                 rd_ok;

    // pin synchronisers; first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sck_s_q   <= 3'h0;
            sdi_s_q   <= 2'h0;
            le_s_q    <= 2'h3;
            ce_s_q    <= 2'h0;
            fv_s_q    <= 2'h0;
            fsym_s1_q <= 3'h0;
            fsym_s2_q <= 3'h0;
        end else begin
            sck_s_q   <= {sck_s_q[1:0], serial_clock};
            sdi_s_q   <= {sdi_s_q[0], serial_data};
            le_s_q    <= {le_s_q[0], latch_enable};
            ce_s_q    <= {ce_s_q[0], chip_enable};
            fv_s_q    <= {fv_s_q[0], fsk_symbol_valid};
            fsym_s1_q <= fsk_symbol_pins;
            fsym_s2_q <= fsym_s1_q;
        end
    end

    // edge found between second and third stages
    assign sck_rise = sck_s_q[1] && !sck_s_q[2];

    // (RULE_03) latch high gates clocks
    // (RULE_01) shift on rising edge
    assign shift_d = {shift_q[WORD_BITS-2:0], sdi_s_q[1]};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shift_q   <= '0;
            bit_cnt_q <= '0;
        end else if (le_s_q[1]) begin
            bit_cnt_q <= '0;
        end else if (sck_rise && bit_cnt_q <= WORD_LAST) begin
            shift_q   <= shift_d;
            bit_cnt_q <= bit_cnt_q + CNT_BITS'(1);
        end
    end

    // (RULE_02) transfer on 24th edge
    // clocks past the 24th dropped until latch rises
    assign word_done = !le_s_q[1] && sck_rise && bit_cnt_q == WORD_LAST && !port_lock;
    assign wr_addr   = shift_d[ADDR_LSB +: ADDR_BITS];
    assign wr_data   = shift_d[DATA_BITS-1:0];

    // bank; tuning word only stored
    always_ff @(posedge aclk) begin
        if (word_done && int'(wr_addr) < BANK_DEPTH) begin
            bank_q[wr_addr] <= wr_data;
        end
    end

    // flopped so decode has a reset value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            main_q <= '0;
        end else if (word_done && wr_addr == BA_MAIN) begin
            main_q <= wr_data;
        end
    end

    // calibration kick on every main control write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cal_start <= 1'b0;
        end else begin
            cal_start <= word_done && wr_addr == BA_MAIN;
        end
    end

    // (RULE_07) arbitrary level from serial path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fast_step_q <= '0;
        end else if (word_done && wr_addr == BA_FSK_FAST) begin
            fast_step_q <= wr_data;
        end
    end

    // word count and toggle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            words_q    <= '0;
            word_tog_q <= 1'b0;
        end else if (word_done) begin
            words_q    <= words_q + 16'h0001;
            word_tog_q <= !word_tog_q;
        end
    end

    // (RULE_06) two, four or eight levels
    always_comb begin
        unique case (main_q[MC_LEVELS +: 2])
            2'b00:   sym_mask = 3'h1;
            2'b01:   sym_mask = 3'h3;
            default: sym_mask = 3'h7;
        endcase
    end

    // symbol taken only while valid is high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sym_q <= 3'h0;
        end else if (fv_s_q[1]) begin
            sym_q <= fsym_s2_q & sym_mask;
        end
    end

    assign route    = ssc_route_t'(main_q[MC_ROUTE +: 2]);
    assign fsk_mode = ssc_fsk_t'(main_q[MC_FSK +: 2]);

    // (RULE_08) fsk offsets the n-divider
    always_comb begin
        unique case (fsk_mode)
            SSC_FSK_PIN:  fsk_step = bank_q[BA_FSK_STEP + 7'(sym_q)];
            SSC_FSK_FAST: fsk_step = fast_step_q;
            default:      fsk_step = '0;
        endcase
    end

    assign port_lock = ctrl_q[0];
    assign soft_pd   = ctrl_q[1];

    // decoded outputs, all registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            powered_down         <= 1'b1;
            pll_mode             <= 1'b0;
            tx_enable            <= 1'b0;
            rx_enable            <= 1'b0;
            freq_sel_two         <= 1'b0;
            dsm_order            <= 2'h0;
            fraction_denominator <= '0;
            n_divider            <= '0;
            pump_current_sum     <= '0;
        end else begin
            // (RULE_14) register bit or chip enable
            powered_down <= main_q[MC_PD] || !ce_s_q[1] || soft_pd;
            // (RULE_10) synthesizer or pll mode
            pll_mode     <= main_q[MC_PLL];
            // (RULE_12) transmit, receive or fanout
            tx_enable    <= route == SSC_ROUTE_TX || route == SSC_ROUTE_BOTH;
            rx_enable    <= route == SSC_ROUTE_RX || route == SSC_ROUTE_BOTH;
            // (RULE_13) port switch picks frequency
            freq_sel_two <= route == SSC_ROUTE_RX;
            // (RULE_11) order one to four, 24-bit denominator
            dsm_order            <= main_q[MC_ORDER +: 2];
            fraction_denominator <= {bank_q[BA_DEN_HI][7:0], bank_q[BA_DEN_LO]};
            n_divider <= (route == SSC_ROUTE_RX ? bank_q[BA_N_TWO] : bank_q[BA_N_ONE])
                         + fsk_step;
            // (RULE_09) sum of active pump pair
            if (main_q[MC_PLL]) begin
                pump_current_sum <= 6'(bank_q[BA_PUMP_EXT][0 +: PUMP_W])
                                  + 6'(bank_q[BA_PUMP_EXT][PUMP_DN +: PUMP_W]);
            end else begin
                pump_current_sum <= 6'(bank_q[BA_PUMP_INT][0 +: PUMP_W])
                                  + 6'(bank_q[BA_PUMP_INT][PUMP_DN +: PUMP_W]);
            end
        end
    end

    // status pin source chosen by main control
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            multiplexed_status_out <= 1'b0;
        end else begin
            unique case (main_q[MC_MUXSEL +: 2])
                2'b00: multiplexed_status_out <= 1'b0;
                2'b01: multiplexed_status_out <= pll_mode;
                2'b10: multiplexed_status_out <= powered_down;
                2'b11: multiplexed_status_out <= word_tog_q;
            endcase
        end
    end

    // axi write: aw and w in either order
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
    assign wr_go         = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // software control and bank window select
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q     <= CTRL_RESET;
            bank_sel_q <= '0;
        end else if (wr_go && w_strb_q[0]) begin
            if (aw_addr_q == AX_CONTROL) begin
                ctrl_q <= w_data_q[1:0];
            end
            if (aw_addr_q == AX_BANK_SEL) begin
                bank_sel_q <= w_data_q[ADDR_BITS-1:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_q == AX_CONTROL || aw_addr_q == AX_BANK_SEL)
                            ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // axi read decode
    always_comb begin
        rd_val = '0;
        rd_ok  = 1'b1;
        unique case (s_axi_araddr)
            AX_CONTROL:  rd_val = {30'h0, ctrl_q};
            AX_STATUS:   rd_val = {words_q, 3'h0, bit_cnt_q, 2'h0, tx_enable, rx_enable,
                                   freq_sel_two, pll_mode, powered_down, le_s_q[1]};
            AX_BANK_SEL: rd_val = {25'h0, bank_sel_q};
            AX_BANK_DAT: rd_val = {16'h0, bank_q[bank_sel_q]};
            AX_N_ACTIVE: rd_val = {10'h0, pump_current_sum, n_divider};
            AX_DEN:      rd_val = {6'h0, dsm_order, fraction_denominator};
            default:     rd_ok  = 1'b0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // ssc_port
`default_nettype wire

// *** ssc_port_properties.sv ***
/* checker for the serial config port: pin, word and bus timing.
   bound to ssc_port; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module ssc_port_properties (
    // system
    input wire logic       aclk,
    input wire logic       aresetn,
    // pins
    input wire logic       serial_clock,
    input wire logic       latch_enable,
    input wire logic       chip_enable,
    // decoded
    input wire logic       powered_down,
    input wire logic       pll_mode,
    input wire logic       tx_enable,
    input wire logic       rx_enable,
    input wire logic       freq_sel_two,
    input wire logic [1:0] dsm_order,
    input wire logic       cal_start,
    // bus
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic       sc_q;
    logic       le_q;
    logic [5:0] edges_q;
    // cleared on latch fall, so the count outlives the latch rise
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sc_q    <= 1'b0;
            le_q    <= 1'b1;
            edges_q <= 6'h00;
        end else begin
            sc_q <= serial_clock;
            le_q <= latch_enable;
            if (le_q && !latch_enable)
                edges_q <= 6'h00;
            else if (!latch_enable && serial_clock && !sc_q)
                edges_q <= edges_q + 6'h01;
        end
    end
    property p_ce_down;
        !chip_enable [*5] |-> powered_down;
    endproperty
    a_ce_down: assert property (p_ce_down) else $error("chip enable low, still up");
    property p_freq_route;
        freq_sel_two == (rx_enable && !tx_enable);
    endproperty
    a_freq_route: assert property (p_freq_route) else $error("freq select off route");
    property p_latch_hold;
        latch_enable [*8] |=> $stable(pll_mode) && $stable(dsm_order) && $stable(tx_enable);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("config moved, latch high");
    property p_cal_pulse;
        cal_start |=> !cal_start;
    endproperty
    a_cal_pulse: assert property (p_cal_pulse) else $error("cal start too long");
    property p_cal_count;
        cal_start |-> edges_q == 6'h18;
    endproperty
    a_cal_count: assert property (p_cal_count) else $error("cal start off 24th edge");
    property p_b_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_b_answer: assert property (p_b_answer) else $error("write response late");
    property p_aw_block;
        s_axi_bvalid |-> !s_axi_awready;
    endproperty
    a_aw_block: assert property (p_aw_block) else $error("address taken during response");
    property p_r_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_r_answer: assert property (p_r_answer) else $error("read response late");
    c_cal: cover property (cal_start);
    c_rx: cover property (freq_sel_two);
    c_pd: cover property (powered_down && chip_enable);
endmodule // ssc_port_properties
bind ssc_port ssc_port_properties u_props (
    .aclk, .aresetn, .serial_clock, .latch_enable, .chip_enable, .powered_down,
    .pll_mode, .tx_enable, .rx_enable, .freq_sel_two, .dsm_order, .cal_start,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid
);
`default_nettype wire

// *** tb_top.sv ***
/* bench for ssc_port against a behavioural model.
   assumes the host model and bound checker. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import ssc_pkg::*;
    logic        aclk, aresetn, chip_enable, fsk_symbol_valid, cal_start;
    logic        serial_clock, serial_data, latch_enable, multiplexed_status_out;
    logic        powered_down, pll_mode, tx_enable, rx_enable, freq_sel_two;
    logic [2:0]  fsk_symbol_pins;
    logic [1:0]  dsm_order, s_axi_bresp, s_axi_rresp, r, ctl;
    logic [23:0] fraction_denominator;
    logic [15:0] n_divider, exp_n;
    logic [5:0]  pump_current_sum, exp_pump;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [15:0] bk [128];
    int          num_errors, samples_checked, seed, cal_seen, cal_exp, lock;
    ssc_port #(.BANK_DEPTH(128)) uut (
        .aclk, .aresetn, .serial_clock, .serial_data, .latch_enable, .chip_enable,
        .multiplexed_status_out, .fsk_symbol_pins, .fsk_symbol_valid, .powered_down,
        .pll_mode, .tx_enable, .rx_enable, .freq_sel_two, .dsm_order,
        .fraction_denominator, .n_divider, .pump_current_sum, .cal_start,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready
    );
    ssc_host_model host (.aclk, .serial_clock, .serial_data, .latch_enable);
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    always @(posedge aclk) if (cal_start === 1'b1) cal_seen <= cal_seen + 1;
    task automatic chk_cfg(input string nm, input logic [23:0] e, input logic [23:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic chk_bus(input string nm, input logic [33:0] e, input logic [33:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic check_all;
        logic [15:0] m;
        logic [15:0] st;
        logic [9:0]  pp;
        logic [2:0]  msk;
        logic [1:0]  rt;
        m   = bk[0];
        rt  = m[3:2];
        msk = m[7:6] == 2'h0 ? 3'h1 : (m[7:6] == 2'h1 ? 3'h3 : 3'h7);
        st  = m[5:4] == 2'h1 ? bk[8 + (fsk_symbol_pins & msk)] : 16'h0000;
        st  = m[5:4] == 2'h2 ? bk[7] : st;
        pp  = m[1] ? bk[6][9:0] : bk[5][9:0];
        exp_n    = (rt == 2'h1 ? bk[2] : bk[1]) + st;
        exp_pump = pp[4:0] + pp[9:5];
        chk_cfg("powered_down", m[0] | !chip_enable | ctl[1], powered_down);
        chk_cfg("pll_mode", m[1], pll_mode);
        chk_cfg("tx_enable", rt == 2'h0 || rt == 2'h2, tx_enable);
        chk_cfg("rx_enable", rt == 2'h1 || rt == 2'h2, rx_enable);
        chk_cfg("freq_sel_two", rt == 2'h1, freq_sel_two);
        chk_cfg("dsm_order", m[9:8], dsm_order);
        chk_cfg("denominator", {bk[4][7:0], bk[3]}, fraction_denominator);
        chk_cfg("n_divider", exp_n, n_divider);
        chk_cfg("pump_sum", exp_pump, pump_current_sum);
    endtask
    task automatic wr_word(input logic [6:0] a, input logic [15:0] v);
        host.send_word({1'b0, a, v});
        if (lock == 0) begin
            bk[a] = v;
            cal_exp += (a == BA_MAIN);
        end
        repeat (8) @(posedge aclk);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        logic aw, wv, bv;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(negedge aclk);
            {aw, wv, bv, r} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (wv) s_axi_wvalid <= 1'b0;
        end while (bv !== 1'b1);
    endtask
    task automatic axi_rd(input logic [7:0] a);
        logic ar, rv;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            {ar, rv, r, d} = {s_axi_arready, s_axi_rvalid, s_axi_rresp, s_axi_rdata};
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
        end while (rv !== 1'b1);
    endtask
    task automatic final_report;
        $display("checks %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge aclk);
        num_errors++;
        final_report();
    end
    initial begin
        seed = 32'h8a25;
        {num_errors, samples_checked, cal_seen, cal_exp, lock} = '0;
        {aresetn, ctl, fsk_symbol_pins, fsk_symbol_valid} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_araddr, s_axi_arvalid} = '0;
        {s_axi_bready, s_axi_rready} = 2'h3;
        chip_enable = 1'b1;
        s_axi_wstrb = 4'hF;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        for (int a = 1; a < 16; a++) wr_word(7'(a), 16'($random(seed)));
        wr_word(BA_MAIN, 16'h0300);
        check_all();
        // every route in both oscillator modes
        for (int i = 0; i < 8; i++) begin
            wr_word(BA_MAIN, {12'h000, 3'(i), 1'b0});
            check_all();
        end
        fsk_symbol_valid <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            fsk_symbol_pins <= 3'($random(seed));
            wr_word(BA_MAIN, {8'h00, 2'(i % 3), 6'h10});
            check_all();
            fsk_symbol_pins <= 3'($random(seed));
            repeat (8) @(posedge aclk);
            check_all();
        end
        wr_word(BA_MAIN, 16'h0024);
        wr_word(BA_FSK_FAST, 16'($random(seed)));
        check_all();
        host.idle_clocks(30);
        repeat (8) @(posedge aclk);
        check_all();
        axi_wr(AX_CONTROL, 32'h00000001);
        lock = 1;
        wr_word(BA_MAIN, 16'h0302);
        check_all();
        axi_wr(AX_CONTROL, 32'h00000000);
        lock = 0;
        chk_bus("control_write", {RESP_OKAY, 32'h0}, {r, 32'h0});
        wr_word(BA_MAIN, 16'h0001);
        check_all();
        wr_word(BA_MAIN, 16'h0000);
        chip_enable <= 1'b0;
        repeat (8) @(posedge aclk);
        check_all();
        chip_enable <= 1'b1;
        axi_wr(AX_CONTROL, 32'h00000002);
        ctl = 2'h2;
        repeat (4) @(posedge aclk);
        check_all();
        axi_wr(AX_CONTROL, 32'h00000000);
        ctl = 2'h0;
        // tuning value low half
        wr_word(BA_HF_TUNE, 16'h6110);
        axi_wr(AX_BANK_SEL, {25'h0, BA_HF_TUNE});
        axi_rd(AX_BANK_DAT);
        chk_bus("bank_data", {RESP_OKAY, 32'h00006110}, {r, d});
        axi_rd(AX_N_ACTIVE);
        chk_bus("n_active", {RESP_OKAY, 10'h000, exp_pump, exp_n}, {r, d});
        axi_rd(AX_DEN);
        chk_bus("den", {RESP_OKAY, 6'h00, bk[0][9:8], bk[4][7:0], bk[3]}, {r, d});
        axi_rd(8'h20);
        chk_bus("unmapped_read", {RESP_SLVERR, 32'h0}, {r, d});
        axi_wr(AX_STATUS, 32'hFFFFFFFF);
        chk_bus("status_write", {RESP_SLVERR, 32'h0}, {r, 32'h0});
        chk_cfg("cal_count", 24'(cal_exp), 24'(cal_seen));
        final_report();
    end
endmodule // tb_top
`default_nettype wire
